// *** verilog/tsihc_tx_sys_if.sv ***
// Top of the two-channel transmit system interface with driver high-impedance control.
//
// Operation
// RULE1: Global high-impedance pin high floats both channels' line drivers.
// RULE2: A channel's high-impedance bit floats only that channel's drivers.
// RULE3: Master clock loss floats the drivers of both channels.
// RULE4: Transmit clock loss floats that channel, unless remote loopback or clock-timed pattern.
// RULE5: A powered-down transmit path keeps its drivers floating.
// RULE6: Software reset, pin reset and power-on float all drivers.
// RULE7: Single-rail data is captured on the selected transmit clock edge.
// RULE8: Single-rail bits are coded AMI, HDB3 or B8ZS before the line.
// RULE9: In single-rail mode the system grounds the negative rail input.
// RULE10: Dual-rail inputs are sampled on selectable edge with selectable polarity.
// RULE11: Rails 0/0 and 1/1 give space, 0/1 positive, 1/0 negative.
// RULE12: System supplies transmit clock at 1.544 MHz or 2.048 MHz.
// RULE13: Unmasked transmit clock loss raises the interrupt request.
// RULE14: Clock steady for more than 70 master cycles is declared missing.
// RULE15: Global interrupt mask suppresses every source from the interrupt request.
// RULE16: Clock edges are synchronised, restart the count and clear the missing flag.
// RULE17: Driver high impedance is the OR of all conditions, per channel.
`timescale 1ns/1ps
module tsihc_tx_sys_if
  import tsihc_pkg::*;
#(
  parameter int NCH = NUM_CH,
  parameter int MISS_CYCLES = CLK_MISS_CYCLES
) (
  // Master clock and reset
  input wire logic clock,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Global pins
  input wire logic global_driver_hiz_pin,
  input wire logic mclk_missing_pin,
  // Per-channel transmit clocks and data
  input wire logic [NCH-1:0] tx_line_clock,
  input wire logic [NCH-1:0] tx_single_rail_data,
  input wire logic [NCH-1:0] tx_negative_rail_data,
  // Line driver outputs
  output logic [NCH-1:0] line_driver_outputs_pos,
  output logic [NCH-1:0] line_driver_outputs_neg,
  output logic [NCH-1:0] line_driver_outputs_oe,
  // Interrupt request
  output logic irq
);

  // Address of a channel's configuration register.
  function automatic logic [ADDR_W-1:0] ch_addr(input int ch);
    ch_addr = CH_CFG_OFS + ADDR_W'(ch) * CH_STRIDE;
  endfunction

  // Channel index hit by an address, NCH when no channel register matches.
  function automatic int ch_hit(input logic [ADDR_W-1:0] addr);
    ch_hit = NCH;
    for (int c = 0; c < NCH; c++) begin
      if (addr == ch_addr(c)) begin
        ch_hit = c;
      end
    end
  endfunction

  tsihc_cfg_t [NCH-1:0] cfg_r;
  logic global_irq_mask_r;
  logic [NCH-1:0] event_r;
  logic [NCH-1:0] missing_r;
  logic [NCH-1:0] missing_d_r;
  logic [MISS_CNT_W-1:0] miss_cnt_r [NCH];
  logic [NCH-1:0] tclk_meta_r;
  logic [NCH-1:0] tclk_sync_r;
  logic [NCH-1:0] tclk_prev_r;
  logic [1:0] pin_meta_r;
  logic [1:0] pin_sync_r;
  logic hiz_pin_s;
  logic mclk_miss_s;
  logic acc;
  logic wr_en;
  logic soft_rst;
  logic rd_ok;
  logic [31:0] rd_data;
  logic [NCH-1:0] ch_hiz;
  logic [NCH-1:0] event_set;
  logic [NCH-1:0] event_clr;
  int hit;
  logic link_reset_r;

  // The bus answers with exactly one wait state on every access.
  assign acc = psel & penable & pready;
  assign wr_en = acc & pwrite & ~pslverr;
  assign soft_rst = wr_en & (paddr == GCTRL_OFS) & pwdata[GCTRL_SOFT_RST_BIT];
  assign hit = ch_hit(paddr);

  always_comb begin
    rd_ok = 1'b1;
    rd_data = 32'h0000_0000;
    if (paddr == GCTRL_OFS) begin
      rd_data[GCTRL_IRQ_MASK_BIT] = global_irq_mask_r;
    end else if (paddr == STATUS_OFS) begin
      rd_data[STATUS_MISS_LSB +: NCH] = missing_r;
      rd_data[STATUS_PIN_BIT] = hiz_pin_s;
      rd_data[STATUS_MCLK_BIT] = mclk_miss_s;
      rd_data[STATUS_OE_LSB +: NCH] = line_driver_outputs_oe;
      rd_data[STATUS_IRQ_BIT] = irq;
    end else if (paddr == EVENT_OFS) begin
      rd_data[NCH-1:0] = event_r;
    end else if (hit < NCH) begin
      rd_data[CFG_W-1:0] = cfg_r[hit];
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & penable & ~pready;
      if (psel & penable & ~pready) begin
        pslverr <= ~rd_ok;
        prdata <= (pwrite | ~rd_ok) ? 32'h0000_0000 : rd_data;
      end else begin
        pslverr <= 1'b0;
        prdata <= 32'h0000_0000;
      end
    end
  end

  // RULE6: reset values float drivers.
  always_ff @(posedge clock) begin
    if (reset | soft_rst) begin
      cfg_r <= {NCH{tsihc_cfg_t'(CFG_RST)}};
      global_irq_mask_r <= GCTRL_IRQ_MASK_RST;
    end else if (wr_en) begin
      if (paddr == GCTRL_OFS) begin
        global_irq_mask_r <= pwdata[GCTRL_IRQ_MASK_BIT];
      end
      if (hit < NCH) begin
        cfg_r[hit] <= tsihc_cfg_t'(pwdata[CFG_W-1:0]);
      end
    end
  end

  // Pins from outside pass two flip-flops; only the second stage is read.
  always_ff @(posedge clock) begin
    pin_meta_r <= {mclk_missing_pin, global_driver_hiz_pin};
    pin_sync_r <= pin_meta_r;
    tclk_meta_r <= tx_line_clock;
    tclk_sync_r <= tclk_meta_r;
  end
  assign hiz_pin_s = pin_sync_r[0];
  assign mclk_miss_s = pin_sync_r[1];

  // RULE16: synchronised edge detection.
  // RULE14: steady over threshold.
  always_ff @(posedge clock) begin
    if (reset) begin
      tclk_prev_r <= '0;
      missing_r <= '0;
      missing_d_r <= '0;
      for (int c = 0; c < NCH; c++) begin
        miss_cnt_r[c] <= '0;
      end
    end else begin
      tclk_prev_r <= tclk_sync_r;
      missing_d_r <= missing_r;
      for (int c = 0; c < NCH; c++) begin
        if (tclk_sync_r[c] != tclk_prev_r[c]) begin
          miss_cnt_r[c] <= '0;
          missing_r[c] <= 1'b0;
        end else if (miss_cnt_r[c] > MISS_CNT_W'(MISS_CYCLES)) begin
          missing_r[c] <= 1'b1;
        end else begin
          miss_cnt_r[c] <= miss_cnt_r[c] + MISS_CNT_W'(1);
        end
      end
    end
  end

  // A new loss sets the sticky flag even in the cycle software clears it.
  assign event_set = missing_r & ~missing_d_r;
  assign event_clr = (wr_en && paddr == EVENT_OFS) ? pwdata[NCH-1:0] : '0;

  always_ff @(posedge clock) begin
    if (reset | soft_rst) begin
      event_r <= '0;
    end else begin
      event_r <= (event_r & ~event_clr) | event_set;
    end
  end

  // RULE13: unmasked loss requests interrupt.
  // RULE15: global mask overrides.
  always_ff @(posedge clock) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= 1'b0;
      for (int c = 0; c < NCH; c++) begin
        if (event_r[c] & ~cfg_r[c].int_mask & ~global_irq_mask_r) begin
          irq <= 1'b1;
        end
      end
    end
  end

  // RULE17: OR of conditions.
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      // RULE1: global pin.
      // RULE3: master clock lost.
      // RULE2: channel bit.
      // RULE5: path powered down.
      // RULE4: clock loss exceptions.
      ch_hiz[c] = hiz_pin_s | mclk_miss_s | cfg_r[c].hiz | cfg_r[c].power_down |
                  (missing_r[c] & ~(cfg_r[c].remote_loop | cfg_r[c].pattern_mclk));
    end
  end

  // RULE6: enables low in reset.
  always_ff @(posedge clock) begin
    if (reset) begin
      line_driver_outputs_oe <= '0;
    end else begin
      line_driver_outputs_oe <= ~ch_hiz;
    end
  end

  // Registered so that no combinational glitch of the bus decode reaches the link domain.
  always_ff @(posedge clock) begin
    link_reset_r <= reset | soft_rst;
  end

  // The symbol path keeps running on its own clock; only the enable floats it.
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    tsihc_tx_link u_link (
      .tx_line_clock(tx_line_clock[g]),
      .reset(link_reset_r),
      .cfg(cfg_r[g]),
      .tx_single_rail_data(tx_single_rail_data[g]),
      .tx_negative_rail_data(tx_negative_rail_data[g]),
      .line_pos(line_driver_outputs_pos[g]),
      .line_neg(line_driver_outputs_neg[g])
    );
  end

endmodule

// *** verilog/tsihc_pkg.sv ***
// Shared constants, field layouts and types of the transmit system interface.
package tsihc_pkg;

  // Register map, byte addresses on the APB word grid.
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] GCTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] EVENT_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] CH_CFG_OFS = 8'h0C;
  localparam logic [ADDR_W-1:0] CH_STRIDE = 8'h04;

  // Global control fields.
  localparam int GCTRL_IRQ_MASK_BIT = 0;
  localparam int GCTRL_SOFT_RST_BIT = 1;
  localparam logic GCTRL_IRQ_MASK_RST = 1'b0;

  // Status field positions.
  localparam int STATUS_MISS_LSB = 0;
  localparam int STATUS_PIN_BIT = 2;
  localparam int STATUS_MCLK_BIT = 3;
  localparam int STATUS_OE_LSB = 4;
  localparam int STATUS_IRQ_BIT = 8;

  // Channel count and clock-loss threshold in master clock cycles.
  localparam int NUM_CH = 2;
  localparam int CLK_MISS_CYCLES = 70;
  localparam int MISS_CNT_W = 7;

  // Line code delay, long enough for the eight-zero substitution.
  localparam int ENC_DEPTH = 8;
  localparam int HDB3_RUN = 4;

  // Transmit clock rates the system must supply, in kHz.
  localparam int TCLK_T1_KHZ = 1544;
  localparam int TCLK_E1_KHZ = 2048;

  typedef enum logic [1:0] {
    CODE_AMI,
    CODE_HDB3,
    CODE_B8ZS
  } tsihc_code_t;

  typedef enum logic [1:0] {
    SYM_SPACE,
    SYM_MARK,
    SYM_VIOL,
    SYM_BAL
  } tsihc_sym_t;

  // Per-channel configuration word, bit 0 is the driver high-impedance bit.
  typedef struct packed {
    logic int_mask;
    logic pattern_mclk;
    logic remote_loop;
    logic power_down;
    logic data_invert;
    logic edge_fall;
    tsihc_code_t code;
    logic dual_rail;
    logic hiz;
  } tsihc_cfg_t;

  localparam int CFG_W = 10;
  localparam logic [CFG_W-1:0] CFG_RST = 10'h201;

endpackage

// *** verilog/tsihc_tx_link.sv ***
// Transmit clock domain of one channel: data capture, line coding and symbol output.
`timescale 1ns/1ps
module tsihc_tx_link
  import tsihc_pkg::*;
(
  // Link clock and master-domain reset level
  input wire logic tx_line_clock,
  input wire logic reset,
  // Configuration held in the master domain
  input wire tsihc_cfg_t cfg,
  // System data pins
  input wire logic tx_single_rail_data,
  input wire logic tx_negative_rail_data,
  // Line symbol outputs
  output logic line_pos,
  output logic line_neg
);

  logic [1:0] rst_sync_r;
  logic link_rst;
  tsihc_cfg_t cfg_meta_r;
  tsihc_cfg_t cfg_r;
  logic rise_p_r;
  logic rise_n_r;
  logic fall_p_r;
  logic fall_n_r;
  logic bit_p;
  logic bit_n;
  tsihc_sym_t [ENC_DEPTH-1:0] sym_r;
  tsihc_sym_t [ENC_DEPTH-1:0] sym_nxt;
  logic odd_r;
  logic odd_nxt;
  logic last_pos_r;
  tsihc_sym_t out_sym;
  logic out_pol;

  // Reset and configuration are level signals, so two flip-flops suffice.
  always_ff @(posedge tx_line_clock) begin
    rst_sync_r <= {rst_sync_r[0], reset};
  end
  assign link_rst = rst_sync_r[1];

  always_ff @(posedge tx_line_clock) begin
    cfg_meta_r <= cfg;
    if (link_rst) begin
      cfg_r <= tsihc_cfg_t'(CFG_RST);
    end else begin
      cfg_r <= cfg_meta_r;
    end
  end

  // RULE7: capture on edge.
  // RULE10: both rails sampled.
  always_ff @(posedge tx_line_clock) begin
    rise_p_r <= tx_single_rail_data;
    rise_n_r <= tx_negative_rail_data;
  end

  always_ff @(negedge tx_line_clock) begin
    fall_p_r <= tx_single_rail_data;
    fall_n_r <= tx_negative_rail_data;
  end

  // RULE10: edge and polarity select.
  assign bit_p = (cfg_r.edge_fall ? fall_p_r : rise_p_r) ^ cfg_r.data_invert;
  assign bit_n = (cfg_r.edge_fall ? fall_n_r : rise_n_r) ^ cfg_r.data_invert;

  // RULE8: zero substitution encoder.
  always_comb begin
    sym_nxt = {sym_r[ENC_DEPTH-2:0], (bit_p ? SYM_MARK : SYM_SPACE)};
    odd_nxt = odd_r;
    if (cfg_r.code == CODE_B8ZS && sym_nxt == {ENC_DEPTH{SYM_SPACE}}) begin
      sym_nxt[4] = SYM_VIOL;
      sym_nxt[3] = SYM_BAL;
      sym_nxt[1] = SYM_VIOL;
      sym_nxt[0] = SYM_BAL;
    end else if (cfg_r.code == CODE_HDB3 && sym_nxt[HDB3_RUN-1:0] == {HDB3_RUN{SYM_SPACE}}) begin
      if (!odd_r) begin
        sym_nxt[HDB3_RUN-1] = SYM_BAL;
      end
      sym_nxt[0] = SYM_VIOL;
      odd_nxt = 1'b0;
    end else if (sym_nxt[0] == SYM_MARK) begin
      odd_nxt = ~odd_r;
    end
  end

  assign out_sym = sym_r[ENC_DEPTH-1];
  // A violation repeats the last polarity, every other pulse alternates.
  assign out_pol = (out_sym == SYM_VIOL) ? last_pos_r : ~last_pos_r;

  always_ff @(posedge tx_line_clock) begin
    if (link_rst) begin
      sym_r <= {ENC_DEPTH{SYM_SPACE}};
      odd_r <= 1'b0;
      last_pos_r <= 1'b0;
    end else begin
      sym_r <= sym_nxt;
      odd_r <= odd_nxt;
      if (out_sym != SYM_SPACE) begin
        last_pos_r <= out_pol;
      end
    end
  end

  always_ff @(posedge tx_line_clock) begin
    if (link_rst) begin
      line_pos <= 1'b0;
      line_neg <= 1'b0;
    end else if (cfg_r.dual_rail) begin
      // RULE11: rail pair mapping.
      line_pos <= ~bit_p & bit_n;
      line_neg <= bit_p & ~bit_n;
    end else begin
      line_pos <= (out_sym != SYM_SPACE) & out_pol;
      line_neg <= (out_sym != SYM_SPACE) & ~out_pol;
    end
  end

endmodule

// *** verif/tsihc_tx_sys_if_assertions.sv ***
// Checker for the transmit system interface, bound to its top.
`timescale 1ns/1ps
module tsihc_tx_sys_if_assertions
  import tsihc_pkg::*;
#(
  parameter int NCH = NUM_CH
) (
  // Master clock, reset and bus
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // Pins and outputs
  input wire logic global_driver_hiz_pin,
  input wire logic mclk_missing_pin,
  input wire logic [NCH-1:0] tx_line_clock,
  input wire logic [NCH-1:0] line_driver_outputs_pos,
  input wire logic [NCH-1:0] line_driver_outputs_neg,
  input wire logic [NCH-1:0] line_driver_outputs_oe,
  input wire logic irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // Samples for which each transmit clock held its level; saturates so it never wraps.
  logic [NCH-1:0] seen_r;
  logic [7:0] still_r [NCH];
  always_ff @(posedge clock) begin
    seen_r <= tx_line_clock;
    for (int c = 0; c < NCH; c++) begin
      still_r[c] <= (tx_line_clock[c] != seen_r[c]) ? 8'h00 : still_r[c] + {7'h00, still_r[c] != 8'hff};
    end
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    !pready ##1 (psel && penable && pready);
  endsequence
  a_apb_wait: assert property (s_setup |=> s_answer)
    else $error("bus answer not after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_prdata_idle: assert property (!pready |-> prdata == '0)
    else $error("read data outside answer");
  a_pin_floats: assert property (global_driver_hiz_pin [*4] |-> line_driver_outputs_oe == '0)
    else $error("drivers on while pin high");
  a_mclk_floats: assert property (mclk_missing_pin [*4] |-> line_driver_outputs_oe == '0)
    else $error("drivers on without master clock");
  a_reset_floats: assert property (@(posedge clock) disable iff (1'b0) $fell(reset) |-> (line_driver_outputs_oe == '0) [*2])
    else $error("drivers on after reset");
  a_rails_excl: assert property ((line_driver_outputs_pos & line_driver_outputs_neg) == '0)
    else $error("both rails active");
  a_loss_late: assert property ($rose(irq) |-> still_r[0] > 8'h46 || still_r[NCH-1] > 8'h46)
    else $error("clock loss declared too early");
endmodule
bind tsihc_tx_sys_if tsihc_tx_sys_if_assertions #(.NCH(NCH)) u_check (
  .clock(clock), .reset(reset), .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
  .global_driver_hiz_pin(global_driver_hiz_pin), .mclk_missing_pin(mclk_missing_pin), .tx_line_clock(tx_line_clock),
  .line_driver_outputs_pos(line_driver_outputs_pos), .line_driver_outputs_neg(line_driver_outputs_neg),
  .line_driver_outputs_oe(line_driver_outputs_oe), .irq(irq)
);

// *** verif/tsihc_framer_model.sv ***
// Framer model driving transmit clocks and rail data of both channels.
`timescale 1ns/1ps
module tsihc_framer_model #(
  parameter int NCH = 2
) (
  // Bench controls
  input wire logic [NCH-1:0] run,
  input wire logic [NCH-1:0] dual,
  input wire logic [NCH-1:0] pos_bit,
  input wire logic [NCH-1:0] neg_bit,
  // Pins into the block
  output logic [NCH-1:0] tx_line_clock,
  output logic [NCH-1:0] tx_single_rail_data,
  output logic [NCH-1:0] tx_negative_rail_data
);
  // A stopped clock freezes at its level, which is what loss detection must see.
  // system transmit clock.
  initial begin
    tx_line_clock = '0;
    #1.3;
    forever #3 tx_line_clock = tx_line_clock ^ run;
  end
  assign tx_single_rail_data = pos_bit;
  assign tx_negative_rail_data = dual & neg_bit;
endmodule

// *** verif/testbench.sv ***
// Self-checking bench for the transmit system interface.
`timescale 1ns/1ps
module testbench;
  import tsihc_pkg::*;
  logic clock = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, hiz_pin = 0, mclk_lost = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic pready, pslverr, irq, e, p, n;
  logic [1:0] run = 2'b11, dual = '0, pb = '0, nb = '0, tclk, tsd, tnd, pos, neg, oe;
  int mismatches = 0, n_checks = 0;
  always #20 clock = ~clock;
  tsihc_framer_model #(.NCH(2)) partner (.run(run), .dual(dual), .pos_bit(pb), .neg_bit(nb),
    .tx_line_clock(tclk), .tx_single_rail_data(tsd), .tx_negative_rail_data(tnd));
  tsihc_tx_sys_if #(.NCH(2), .MISS_CYCLES(70)) dut (.clock(clock), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .global_driver_hiz_pin(hiz_pin), .mclk_missing_pin(mclk_lost), .tx_line_clock(tclk),
    .tx_single_rail_data(tsd), .tx_negative_rail_data(tnd), .line_driver_outputs_pos(pos),
    .line_driver_outputs_neg(neg), .line_driver_outputs_oe(oe), .irq(irq));
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
  endtask
  // One bus transfer; the request stands until ready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1;
    k = 0;
    do begin @(posedge clock); k++; end while (pready !== 1'b1 && k < 20);
    q = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
    if (k == 20) begin chk("bus timeout", 1, 0); conclude(); end
    @(posedge clock);
  endtask
  task automatic t_reset();
    chk("oe", 0, oe);
    apb(0, CH_CFG_OFS + CH_STRIDE, 0); chk("cfg1", 32'h0000_0201, q);
    apb(0, 8'h40, 0); chk("slverr", 1, e);
    $display("reset test done");
  endtask
  task automatic t_hiz();
    apb(1, CH_CFG_OFS, 0); apb(1, CH_CFG_OFS + CH_STRIDE, 0); cyc(4); chk("oe", 3, oe);
    apb(1, CH_CFG_OFS, 1); cyc(4); chk("oe", 2, oe);
    apb(1, CH_CFG_OFS, 0); hiz_pin <= 1; cyc(6); chk("oe", 0, oe);
    hiz_pin <= 0; mclk_lost <= 1; cyc(6); chk("oe", 0, oe);
    mclk_lost <= 0; apb(1, CH_CFG_OFS + CH_STRIDE, 32'h0000_0040); cyc(6); chk("oe", 1, oe);
    apb(1, GCTRL_OFS, 2); cyc(4); chk("oe", 0, oe);
    apb(0, CH_CFG_OFS, 0); chk("cfg0", 32'h0000_0201, q);
    $display("hiz test done");
  endtask
  task automatic t_dual();
    dual <= 2'b01;
    for (int i = 0; i < 8; i++) begin
      apb(1, CH_CFG_OFS, {26'h000_0000, {2{i[2]}}, 4'h2});
      pb <= {1'b0, i[1]}; nb <= {1'b0, i[0]}; cyc(8);
      p = i[1] ^ i[2]; n = i[0] ^ i[2];
      chk("rails", {30'h0000_0000, !p && n, p && !n}, {30'h0000_0000, pos[0], neg[0]});
    end
    $display("dual rail test done");
  endtask
  task automatic t_code();
    logic [31:0] np, nn;
    dual <= 2'b00;
    for (int i = 0; i < 6; i++) begin
      apb(1, CH_CFG_OFS, {28'h000_0000, i[2:1], 2'b00});
      pb <= {1'b0, i[0]}; cyc(10);
      np = 0; nn = 0;
      repeat (16) begin @(negedge tclk[0]); np += {31'h0000_0000, pos[0]}; nn += {31'h0000_0000, neg[0]}; end
      chk("pulses", i[0] ? 16 : (i < 2 ? 0 : 8), np + nn);
      chk("positive", i[0] ? 8 : (i < 2 ? 0 : 4), np);
    end
    $display("line code test done");
  endtask
  task automatic t_loss();
    int k;
    apb(1, CH_CFG_OFS, 0); cyc(4); run <= 2'b10;
    k = 0;
    while (irq !== 1'b1 && k < 120) begin @(posedge clock); k++; end
    chk("loss delay", 1, {31'h0000_0000, k > 70 && k < 80});
    if (k == 120) conclude();
    chk("oe", 0, oe[0]);
    apb(0, STATUS_OFS, 0); chk("missing", 1, q & 1);
    run <= 2'b11; cyc(8); chk("oe", 1, oe[0]);
    apb(1, EVENT_OFS, 1); cyc(2); chk("irq", 0, irq);
    apb(1, GCTRL_OFS, 1); apb(1, CH_CFG_OFS, 32'h0000_0080); cyc(4); run <= 2'b10; cyc(100);
    chk("irq", 0, irq);
    chk("oe", 1, oe[0]);
    apb(0, EVENT_OFS, 0); chk("event", 1, q & 1);
    run <= 2'b11;
    $display("clock loss test done");
  endtask
  initial begin
    repeat (6) @(posedge clock);
    reset <= 0;
    @(posedge clock);
    t_reset(); t_hiz(); t_dual(); t_code(); t_loss();
    conclude();
  end
endmodule
